/* File: rtl/reload_timer_pkg.sv */
// Purpose : Shared constants and types for the dual reloadable down-timer.
// Assumes : 4-bit register bus, 16-bit byte addresses.
// Notes   : Offsets are the printed addresses.
package reload_timer_pkg;

  localparam logic [15:0] ADDR_MODE_CTRL   = 16'hFFC0;
  localparam logic [15:0] ADDR_CLK_TONE    = 16'hFFC1;
  localparam logic [15:0] ADDR_T0_DIV_RUN  = 16'hFFC2;
  localparam logic [15:0] ADDR_T1_DIV_RUN  = 16'hFFC3;
  localparam logic [15:0] ADDR_T0_RLD_LO   = 16'hFFC4;
  localparam logic [15:0] ADDR_T0_RLD_HI   = 16'hFFC5;
  localparam logic [15:0] ADDR_T1_RLD_LO   = 16'hFFC6;
  localparam logic [15:0] ADDR_T1_RLD_HI   = 16'hFFC7;
  localparam logic [15:0] ADDR_T0_CNT_LO   = 16'hFFC8;
  localparam logic [15:0] ADDR_T0_CNT_HI   = 16'hFFC9;
  localparam logic [15:0] ADDR_T1_CNT_LO   = 16'hFFCA;
  localparam logic [15:0] ADDR_T1_CNT_HI   = 16'hFFCB;
  localparam logic [15:0] ADDR_IRQ_EN      = 16'hFFE2;
  localparam logic [15:0] ADDR_IRQ_FLAG    = 16'hFFF2;

  // Bit positions inside the 4-bit registers.
  localparam int BIT_CHAIN    = 3;
  localparam int BIT_EVENT    = 2;
  localparam int BIT_FILTER   = 1;
  localparam int BIT_POLARITY = 0;
  localparam int BIT_TONE_SRC = 3;
  localparam int BIT_TONE_EN  = 2;
  localparam int BIT_CLK_T1   = 1;
  localparam int BIT_CLK_T0   = 0;
  localparam int BIT_DIV_MSB  = 3;
  localparam int BIT_DIV_LSB  = 2;
  localparam int BIT_PRELOAD  = 1;
  localparam int BIT_RUN      = 0;

  localparam logic [3:0] RST_NIBBLE = 4'h0;
  localparam logic [7:0] RST_COUNT  = 8'h00;

  // Prescaler ratios for codes 00, 01, 10, 11.
  localparam int DIV_CODE0 = 1;
  localparam int DIV_CODE1 = 4;
  localparam int DIV_CODE2 = 32;
  localparam int DIV_CODE3 = 256;

  // Filter clock frequency in Hz and system clock in Hz.
  localparam int FILTER_HZ     = 2048;
  localparam int SYS_CLK_HZ    = 25000000;
  localparam int FILTER_CYCLES = SYS_CLK_HZ / FILTER_HZ;

  typedef struct packed {
    logic        wr;
    logic        rd;
    logic [15:0] addr;
    logic [3:0]  wdata;
  } reg_req_t;

  typedef struct packed {
    logic chain;
    logic event_mode;
    logic filter;
    logic polarity;
  } mode_ctrl_t;

endpackage : reload_timer_pkg

/* File: rtl/dual_reload_down_timer.sv */
// Purpose : Two 8-bit reloadable down-counters, chainable to 16 bits, with tone output.
// Assumes : slow_clk, fast_clk and ext_count_pin are asynchronous and sampled here.
// Notes   : Count clocks are edges detected in the clk domain.
//
// Decided for this implementation: the address-and-strobe port.
`timescale 1ns/1ps
module dual_reload_down_timer
  import reload_timer_pkg::*;
#(
  parameter int FILTER_DIV = FILTER_CYCLES
) (
  input  wire logic                        clk,
  input  wire logic                        rst_b,
  input  wire reload_timer_pkg::reg_req_t  req,
  output logic [3:0]                       rdata,
  input  wire logic                        slow_clk,
  input  wire logic                        fast_clk,
  input  wire logic                        ext_count_pin,
  output logic                             tone_out_pin,
  output logic                             irq_t0,
  output logic                             irq_t1
);
  import reload_timer_pkg::*;

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  mode_ctrl_t  mode_q;
  logic        tone_out_source_sel_q, tone_out_en_q;
  logic [1:0]  src_clk_sel_q;
  logic [1:0]  div_sel_t0_q, div_sel_t1_q;
  logic [1:0]  run_q;
  logic [7:0]  reload_value_t0_q, reload_value_t1_q;
  logic [7:0]  count_value_t0_q, count_value_t1_q;
  logic [3:0]  held_hi_t0_q, held_hi_t1_q;
  logic [1:0]  irq_enable_q;
  logic [1:0]  scratch_q;
  logic [1:0]  irq_flag_q;
  logic        tone_out_q;
  logic [1:0]  preload_d;
  logic        wr_en;

  assign wr_en = req.wr;

  function automatic logic hit(input reg_req_t r, input logic [15:0] a);
    hit = r.addr == a;
  endfunction : hit

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      mode_q                <= '0;
      tone_out_source_sel_q <= 1'b0;
      tone_out_en_q         <= 1'b0;
      src_clk_sel_q         <= 2'b00;
      div_sel_t0_q          <= 2'b00;
      div_sel_t1_q          <= 2'b00;
      run_q                 <= 2'b00;
      irq_enable_q          <= 2'b00;
      scratch_q             <= 2'b00;
    end else if (wr_en) begin
      if (hit(req, ADDR_MODE_CTRL)) begin
        mode_q <= mode_ctrl_t'(req.wdata);
      end
      if (hit(req, ADDR_CLK_TONE)) begin
        tone_out_source_sel_q <= req.wdata[BIT_TONE_SRC];
        tone_out_en_q         <= req.wdata[BIT_TONE_EN];
        src_clk_sel_q         <= {req.wdata[BIT_CLK_T1], req.wdata[BIT_CLK_T0]};
      end
      if (hit(req, ADDR_T0_DIV_RUN)) begin
        div_sel_t0_q <= req.wdata[BIT_DIV_MSB:BIT_DIV_LSB];
        run_q[0]     <= req.wdata[BIT_RUN];
      end
      if (hit(req, ADDR_T1_DIV_RUN)) begin
        div_sel_t1_q <= req.wdata[BIT_DIV_MSB:BIT_DIV_LSB];
        run_q[1]     <= req.wdata[BIT_RUN];
      end
      if (hit(req, ADDR_IRQ_EN)) begin
        scratch_q    <= req.wdata[3:2];
        irq_enable_q <= req.wdata[1:0];
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      reload_value_t0_q <= RST_COUNT;
      reload_value_t1_q <= RST_COUNT;
    end else if (wr_en) begin
      if (hit(req, ADDR_T0_RLD_LO)) reload_value_t0_q[3:0] <= req.wdata;
      if (hit(req, ADDR_T0_RLD_HI)) reload_value_t0_q[7:4] <= req.wdata;
      if (hit(req, ADDR_T1_RLD_LO)) reload_value_t1_q[3:0] <= req.wdata;
      if (hit(req, ADDR_T1_RLD_HI)) reload_value_t1_q[7:4] <= req.wdata;
    end
  end

  always_comb begin
    preload_d[0] = wr_en && hit(req, ADDR_T0_DIV_RUN) && req.wdata[BIT_PRELOAD];
    preload_d[1] = wr_en && hit(req, ADDR_T1_DIV_RUN) && req.wdata[BIT_PRELOAD];
  end

  // ----------------------------------------------------------------
  // Input synchronisers and edge detection
  // ----------------------------------------------------------------
  logic [1:0] slow_sync_q, fast_sync_q, pin_sync_q;
  logic       slow_last_q, fast_last_q, pin_last_q;

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      slow_sync_q <= 2'b00;
      fast_sync_q <= 2'b00;
      pin_sync_q  <= 2'b11;
      slow_last_q <= 1'b0;
      fast_last_q <= 1'b0;
      pin_last_q  <= 1'b1;
    end else begin
      slow_sync_q <= {slow_sync_q[0], slow_clk};
      fast_sync_q <= {fast_sync_q[0], fast_clk};
      pin_sync_q  <= {pin_sync_q[0], ext_count_pin};
      slow_last_q <= slow_sync_q[1];
      fast_last_q <= fast_sync_q[1];
      pin_last_q  <= pin_sync_q[1];
    end
  end

  logic slow_tick, fast_tick;
  assign slow_tick = slow_sync_q[1] & ~slow_last_q;
  assign fast_tick = fast_sync_q[1] & ~fast_last_q;

  // ----------------------------------------------------------------
  // Glitch filter: pin level accepted on the second 2048 Hz falling edge
  // ----------------------------------------------------------------
  logic [$clog2(FILTER_DIV+1)-1:0] filt_cnt_q;
  logic       filt_fall;
  logic [1:0] filt_seen_q;
  logic       filt_level_q, filt_last_q;

  assign filt_fall = filt_cnt_q == '0;

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      filt_cnt_q <= '0;
    end else if (filt_fall) begin
      filt_cnt_q <= ($clog2(FILTER_DIV+1))'(FILTER_DIV - 1);
    end else begin
      filt_cnt_q <= filt_cnt_q - 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      filt_seen_q  <= 2'b00;
      filt_level_q <= 1'b1;
      filt_last_q  <= 1'b1;
    end else begin
      filt_last_q <= filt_level_q;
      if (pin_last_q == filt_level_q) begin
        filt_seen_q <= 2'b00;
      end else if (filt_fall) begin
        if (filt_seen_q == 2'b01) begin
          filt_level_q <= pin_last_q;
          filt_seen_q  <= 2'b00;
        end else begin
          filt_seen_q <= 2'b01;
        end
      end
    end
  end

  // Event edge selected from filtered or raw level and polarity.
  logic ev_cur, ev_prev, ev_tick;
  always_comb begin
    ev_cur  = mode_q.filter ? filt_level_q : pin_last_q;
    ev_prev = mode_q.filter ? filt_last_q : pin_sync_q[1];
    // Raw path compares the newer sample to the older one.
    if (!mode_q.filter) begin
      ev_cur  = pin_sync_q[1];
      ev_prev = pin_last_q;
    end
    ev_tick = mode_q.polarity ? (ev_cur & ~ev_prev) : (~ev_cur & ev_prev);
  end

  // ----------------------------------------------------------------
  // Prescalers
  // ----------------------------------------------------------------
  function automatic logic [7:0] div_mask(input logic [1:0] code);
    case (code)
      2'b11:   div_mask = 8'(DIV_CODE3 - 1);
      2'b10:   div_mask = 8'(DIV_CODE2 - 1);
      2'b01:   div_mask = 8'(DIV_CODE1 - 1);
      default: div_mask = 8'(DIV_CODE0 - 1);
    endcase
  endfunction : div_mask

  logic [7:0] pre_t0_q, pre_t1_q;
  logic       src_t0, src_t1, pre_tick_t0, pre_tick_t1;

  assign src_t0      = src_clk_sel_q[0] ? fast_tick : slow_tick;
  assign src_t1      = src_clk_sel_q[1] ? fast_tick : slow_tick;
  assign pre_tick_t0 = src_t0 && ((pre_t0_q & div_mask(div_sel_t0_q)) == div_mask(div_sel_t0_q));
  assign pre_tick_t1 = src_t1 && ((pre_t1_q & div_mask(div_sel_t1_q)) == div_mask(div_sel_t1_q));

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      pre_t0_q <= 8'h00;
      pre_t1_q <= 8'h00;
    end else begin
      if (!run_q[0] || preload_d[0]) pre_t0_q <= 8'h00;
      else if (src_t0) pre_t0_q <= pre_t0_q + 8'h01;
      if (!run_q[1] || preload_d[1]) pre_t1_q <= 8'h00;
      else if (src_t1) pre_t1_q <= pre_t1_q + 8'h01;
    end
  end

  // ----------------------------------------------------------------
  // Counters
  // ----------------------------------------------------------------
  logic clk_t0, clk_t1, uf_t0, uf_t1;
  // Event mode drops the prescaler path of timer 0 only.
  assign clk_t0 = run_q[0] && (mode_q.event_mode ? ev_tick : pre_tick_t0);
  assign uf_t0  = clk_t0 && count_value_t0_q == 8'h00;
  // Chained mode steps timer 1 from timer 0 underflow.
  assign clk_t1 = mode_q.chain ? uf_t0 : (run_q[1] && pre_tick_t1);
  assign uf_t1  = clk_t1 && count_value_t1_q == 8'h00;

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      count_value_t0_q <= RST_COUNT;
    end else if (preload_d[0] || uf_t0) begin
      count_value_t0_q <= reload_value_t0_q;
    end else if (clk_t0) begin
      count_value_t0_q <= count_value_t0_q - 8'h01;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      count_value_t1_q <= RST_COUNT;
    end else if (preload_d[1] || uf_t1) begin
      count_value_t1_q <= reload_value_t1_q;
    end else if (clk_t1) begin
      count_value_t1_q <= count_value_t1_q - 8'h01;
    end
  end

  // ----------------------------------------------------------------
  // Flags, tone and interrupt outputs
  // ----------------------------------------------------------------
  logic [1:0] uf_irq, flag_clr;
  assign uf_irq   = {uf_t1, uf_t0 && !mode_q.chain};
  assign flag_clr = (wr_en && hit(req, ADDR_IRQ_FLAG)) ? req.wdata[1:0] : 2'b00;

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      irq_flag_q <= 2'b00;
    end else begin
      irq_flag_q <= (irq_flag_q & ~flag_clr) | uf_irq;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      irq_t0 <= 1'b0;
      irq_t1 <= 1'b0;
    end else begin
      irq_t0 <= irq_flag_q[0] & irq_enable_q[0];
      irq_t1 <= irq_flag_q[1] & irq_enable_q[1];
    end
  end

  logic tone_uf;
  assign tone_uf = (tone_out_source_sel_q || mode_q.chain) ? uf_t1 : uf_t0;

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      tone_out_q   <= 1'b0;
      tone_out_pin <= 1'b1;
    end else begin
      if (tone_uf) tone_out_q <= ~tone_out_q;
      tone_out_pin <= tone_out_en_q ? tone_out_q : 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // Read port
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      held_hi_t0_q <= RST_NIBBLE;
      held_hi_t1_q <= RST_NIBBLE;
    end else if (req.rd) begin
      if (hit(req, ADDR_T0_CNT_LO)) held_hi_t0_q <= count_value_t0_q[7:4];
      if (hit(req, ADDR_T1_CNT_LO)) held_hi_t1_q <= count_value_t1_q[7:4];
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      rdata <= RST_NIBBLE;
    end else if (req.rd) begin
      case (req.addr)
        ADDR_MODE_CTRL:  rdata <= 4'(mode_q);
        ADDR_CLK_TONE:   rdata <= {tone_out_source_sel_q, tone_out_en_q, src_clk_sel_q};
        ADDR_T0_DIV_RUN: rdata <= {div_sel_t0_q, 1'b0, run_q[0]};
        ADDR_T1_DIV_RUN: rdata <= {div_sel_t1_q, 1'b0, run_q[1]};
        ADDR_T0_RLD_LO:  rdata <= reload_value_t0_q[3:0];
        ADDR_T0_RLD_HI:  rdata <= reload_value_t0_q[7:4];
        ADDR_T1_RLD_LO:  rdata <= reload_value_t1_q[3:0];
        ADDR_T1_RLD_HI:  rdata <= reload_value_t1_q[7:4];
        ADDR_T0_CNT_LO:  rdata <= count_value_t0_q[3:0];
        ADDR_T0_CNT_HI:  rdata <= held_hi_t0_q;
        ADDR_T1_CNT_LO:  rdata <= count_value_t1_q[3:0];
        ADDR_T1_CNT_HI:  rdata <= held_hi_t1_q;
        ADDR_IRQ_EN:     rdata <= {scratch_q, irq_enable_q};
        ADDR_IRQ_FLAG:   rdata <= {2'b00, irq_flag_q};
        default:         rdata <= RST_NIBBLE;
      endcase
    end else begin
      rdata <= RST_NIBBLE;
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  a_uf_reload: assert property (@(posedge clk) disable iff (!rst_b)
    uf_t0 && !preload_d[0] |=> count_value_t0_q == $past(reload_value_t0_q))
    else $error("timer 0 did not reload on underflow");
  a_flag_set: assert property (@(posedge clk) disable iff (!rst_b)
    uf_irq[1] |=> irq_flag_q[1])
    else $error("timer 1 flag not set on underflow");
  a_chain_no_t0_irq: assert property (@(posedge clk) disable iff (!rst_b)
    mode_q.chain && !irq_flag_q[0] && !flag_clr[0] |=> !irq_flag_q[0] || !$past(mode_q.chain))
    else $error("timer 0 flagged while chained");
  a_tone_idle_high: assert property (@(posedge clk) disable iff (!rst_b)
    !tone_out_en_q |=> tone_out_pin)
    else $error("tone pin not high while disabled");
  a_tone_toggle: assert property (@(posedge clk) disable iff (!rst_b)
    tone_uf |=> tone_out_q != $past(tone_out_q))
    else $error("tone did not toggle");
  a_stop_holds: assert property (@(posedge clk) disable iff (!rst_b)
    !run_q[0] && !preload_d[0] |=> $stable(count_value_t0_q))
    else $error("stopped timer 0 changed");
  a_preload_copy: assert property (@(posedge clk) disable iff (!rst_b)
    preload_d[1] |=> count_value_t1_q == $past(reload_value_t1_q))
    else $error("preload did not copy reload value");
  a_hold_high: assert property (@(posedge clk) disable iff (!rst_b)
    req.rd && hit(req, ADDR_T0_CNT_LO) |=> held_hi_t0_q == $past(count_value_t0_q[7:4]))
    else $error("high nibble not frozen");

endmodule : dual_reload_down_timer

/* File: sim/event_source_model.sv */
// Purpose : Far side: oscillator ticks, external event pulses, tone load.
// Assumes : Pulses are several clk cycles wide so the sampler sees them.
// Notes   : Oscillators idle low and the event pin idles high, as with a pull-up.
`timescale 1ns/1ps
module event_source_model (
  input  wire logic clk,
  input  wire logic tone_out_pin,
  output logic      slow_clk,
  output logic      fast_clk,
  output logic      ext_count_pin
);
  logic [2:0] lines;
  int         tone_edges;

  assign slow_clk      = lines[0];
  assign fast_clk      = lines[1];
  assign ext_count_pin = lines[2];

  initial begin
    lines = 3'h4;
    tone_edges = 0;
  end

  // The tone load counts every level change it sees.
  always @(tone_out_pin) begin
    tone_edges = tone_edges + 1;
  end

  // Line 0 slow, 1 fast, 2 event pin; each pulse leaves its idle level once and returns.
  task automatic pulse(input int sel, input int n, input int w);
    for (int i = 0; i < n; i++) begin
      @(posedge clk);
      lines[sel] <= ~lines[sel];
      repeat (w) @(posedge clk);
      lines[sel] <= ~lines[sel];
      repeat (w - 1) @(posedge clk);
    end
  endtask : pulse
endmodule : event_source_model

/* File: sim/tb_dual_reload_down_timer.sv */
// Purpose : Self-checking bench for the dual reloadable down-timer.
// Assumes : Count sources are quiet while counts are read.
// Notes   : The filter clock divider is shortened to 8 cycles.
`timescale 1ns/1ps
module tb_dual_reload_down_timer;
  import reload_timer_pkg::*;
  logic       clk, rst_b, tone_out_pin, irq_t0, irq_t1;
  logic       slow_clk, fast_clk, ext_count_pin, lvl;
  logic [3:0] rdata, d;
  logic [7:0] c;
  reg_req_t   req;
  int         n_fail, samples_checked, e0;

  dual_reload_down_timer #(.FILTER_DIV(8)) dut_u (.clk(clk), .rst_b(rst_b), .req(req),
    .rdata(rdata), .slow_clk(slow_clk), .fast_clk(fast_clk), .ext_count_pin(ext_count_pin),
    .tone_out_pin(tone_out_pin), .irq_t0(irq_t0), .irq_t1(irq_t1));
  event_source_model far_u (.clk(clk), .tone_out_pin(tone_out_pin), .slow_clk(slow_clk),
    .fast_clk(fast_clk), .ext_count_pin(ext_count_pin));

  always #20 clk = ~clk;

  // --------------------------------------------------------------------
  // Bus and check tasks
  // --------------------------------------------------------------------
  task give_verdict;
    $display("checks %0d mismatches %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : give_verdict

  task chk(input logic [7:0] got, input logic [7:0] exp);
    samples_checked++;
    if (got !== exp) begin
      n_fail++;
      $display("[FAIL] t=%0t got %h exp %h", $time, got, exp);
    end
  endtask : chk

  task wr(input logic [15:0] a, input logic [3:0] v);
    @(posedge clk);
    req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: v};
    @(posedge clk);
    req.wr <= 1'b0;
  endtask : wr

  task rd(input logic [15:0] a);
    @(posedge clk);
    req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 4'h0};
    @(posedge clk);
    req.rd <= 1'b0;
    #1;
    d = rdata;
  endtask : rd

  // Low nibble first, so the high nibble comes from the frozen copy.
  task rdc(input logic [15:0] a);
    rd(a);
    c[3:0] = d;
    rd(a + 16'h0001);
    c[7:4] = d;
  endtask : rdc

  task ticks(input int sel, input int n, input int w);
    far_u.pulse(sel, n, w);
    repeat (8) @(posedge clk);
  endtask : ticks

  // --------------------------------------------------------------------
  // Scenarios
  // --------------------------------------------------------------------
  task t_reset;
    for (int i = 0; i < 12; i++) begin
      rd(ADDR_MODE_CTRL + 16'(i));
      chk(8'(d), 8'(RST_NIBBLE));
    end
    rd(ADDR_IRQ_EN);
    chk(8'(d), 8'h00);
    rd(ADDR_IRQ_FLAG);
    chk(8'(d), 8'h00);
    rd(16'hFFD0);
    chk(8'(d), 8'h00);
    chk(8'(tone_out_pin), 8'h01);
    $display("t_reset done");
  endtask : t_reset

  task t_preload;
    wr(ADDR_T0_RLD_LO, 4'hA);
    wr(ADDR_T0_RLD_HI, 4'h5);
    rdc(ADDR_T0_CNT_LO);
    chk(c, RST_COUNT);
    wr(ADDR_T0_DIV_RUN, 4'h2);
    rdc(ADDR_T0_CNT_LO);
    chk(c, 8'h5A);
    rd(ADDR_T0_DIV_RUN);
    chk(8'(d), 8'h00);
    wr(ADDR_T0_CNT_LO, 4'hF);
    wr(ADDR_T0_CNT_HI, 4'hF);
    rdc(ADDR_T0_CNT_LO);
    chk(c, 8'h5A);
    $display("t_preload done");
  endtask : t_preload

  task t_timer;
    wr(ADDR_CLK_TONE, 4'h1);
    wr(ADDR_T0_DIV_RUN, 4'h1);
    ticks(1, 3, 4);
    rdc(ADDR_T0_CNT_LO);
    chk(c, 8'h57);
    ticks(0, 3, 4);
    rdc(ADDR_T0_CNT_LO);
    chk(c, 8'h57);
    wr(ADDR_T0_RLD_LO, 4'h0);
    wr(ADDR_T0_DIV_RUN, 4'h3);
    rd(ADDR_T0_CNT_LO);
    ticks(1, 1, 4);
    rd(ADDR_T0_CNT_HI);
    chk(8'(d), 8'h05);
    wr(ADDR_T0_DIV_RUN, 4'h0);
    ticks(1, 2, 4);
    rdc(ADDR_T0_CNT_LO);
    chk(c, 8'h4F);
    wr(ADDR_T0_DIV_RUN, 4'h7);
    ticks(1, 8, 4);
    rdc(ADDR_T0_CNT_LO);
    chk(c, 8'h4E);
    wr(ADDR_T0_RLD_LO, 4'h1);
    wr(ADDR_T0_RLD_HI, 4'h0);
    wr(ADDR_T0_DIV_RUN, 4'h3);
    ticks(1, 2, 4);
    rdc(ADDR_T0_CNT_LO);
    chk(c, 8'h01);
    rd(ADDR_IRQ_FLAG);
    chk(8'(d), 8'h01);
    chk(8'(irq_t0), 8'h00);
    wr(ADDR_IRQ_EN, 4'h1);
    repeat (3) @(posedge clk);
    chk(8'(irq_t0), 8'h01);
    wr(ADDR_IRQ_FLAG, 4'h0);
    rd(ADDR_IRQ_FLAG);
    chk(8'(d), 8'h01);
    wr(ADDR_IRQ_FLAG, 4'h1);
    rd(ADDR_IRQ_FLAG);
    chk(8'(d), 8'h00);
    chk(8'(irq_t0), 8'h00);
    wr(ADDR_IRQ_EN, 4'h0);
    wr(ADDR_T0_DIV_RUN, 4'h0);
    $display("t_timer done");
  endtask : t_timer

  task t_indep;
    wr(ADDR_CLK_TONE, 4'h0);
    wr(ADDR_T1_RLD_LO, 4'h3);
    wr(ADDR_T1_DIV_RUN, 4'h3);
    ticks(0, 1, 4);
    rdc(ADDR_T1_CNT_LO);
    chk(c, 8'h02);
    wr(ADDR_CLK_TONE, 4'h2);
    ticks(0, 1, 4);
    ticks(1, 3, 4);
    rdc(ADDR_T1_CNT_LO);
    chk(c, 8'h03);
    rdc(ADDR_T0_CNT_LO);
    chk(c, 8'h01);
    rd(ADDR_IRQ_FLAG);
    chk(8'(d), 8'h02);
    wr(ADDR_IRQ_FLAG, 4'h3);
    wr(ADDR_T1_DIV_RUN, 4'h0);
    $display("t_indep done");
  endtask : t_indep

  task t_event;
    wr(ADDR_T0_RLD_LO, 4'h0);
    wr(ADDR_T0_RLD_HI, 4'h2);
    wr(ADDR_CLK_TONE, 4'h1);
    wr(ADDR_MODE_CTRL, 4'h4);
    wr(ADDR_T0_DIV_RUN, 4'h3);
    rd(ADDR_MODE_CTRL);
    chk(8'(d), 8'h04);
    ticks(2, 3, 4);
    rdc(ADDR_T0_CNT_LO);
    chk(c, 8'h1D);
    ticks(1, 2, 4);
    rdc(ADDR_T0_CNT_LO);
    chk(c, 8'h1D);
    wr(ADDR_MODE_CTRL, 4'h5);
    ticks(2, 2, 4);
    rdc(ADDR_T0_CNT_LO);
    chk(c, 8'h1B);
    wr(ADDR_MODE_CTRL, 4'h6);
    ticks(2, 2, 40);
    repeat (24) @(posedge clk);
    ticks(2, 1, 2);
    rdc(ADDR_T0_CNT_LO);
    chk(c, 8'h19);
    wr(ADDR_MODE_CTRL, 4'h3);
    ticks(1, 2, 4);
    rdc(ADDR_T0_CNT_LO);
    chk(c, 8'h17);
    wr(ADDR_MODE_CTRL, 4'h0);
    wr(ADDR_T0_DIV_RUN, 4'h0);
    $display("t_event done");
  endtask : t_event

  task t_tone;
    wr(ADDR_T0_RLD_LO, 4'h1);
    wr(ADDR_T0_RLD_HI, 4'h0);
    wr(ADDR_CLK_TONE, 4'h5);
    wr(ADDR_T0_DIV_RUN, 4'h3);
    repeat (4) @(posedge clk);
    lvl = tone_out_pin;
    e0 = far_u.tone_edges;
    ticks(1, 2, 4);
    chk(8'(tone_out_pin), 8'(!lvl));
    ticks(1, 4, 4);
    chk(8'(far_u.tone_edges - e0), 8'h03);
    wr(ADDR_CLK_TONE, 4'hD);
    repeat (4) @(posedge clk);
    e0 = far_u.tone_edges;
    ticks(1, 4, 4);
    chk(8'(far_u.tone_edges - e0), 8'h00);
    wr(ADDR_CLK_TONE, 4'h9);
    repeat (3) @(posedge clk);
    chk(8'(tone_out_pin), 8'h01);
    wr(ADDR_T0_DIV_RUN, 4'h0);
    wr(ADDR_IRQ_FLAG, 4'h3);
    $display("t_tone done");
  endtask : t_tone

  task t_chain;
    wr(ADDR_MODE_CTRL, 4'h8);
    wr(ADDR_CLK_TONE, 4'h1);
    wr(ADDR_T1_RLD_LO, 4'h1);
    wr(ADDR_T0_DIV_RUN, 4'h3);
    wr(ADDR_T1_DIV_RUN, 4'h3);
    ticks(1, 2, 4);
    rdc(ADDR_T0_CNT_LO);
    chk(c, 8'h01);
    rdc(ADDR_T1_CNT_LO);
    chk(c, 8'h00);
    rd(ADDR_IRQ_FLAG);
    chk(8'(d), 8'h00);
    ticks(1, 2, 4);
    rdc(ADDR_T1_CNT_LO);
    chk(c, 8'h01);
    rd(ADDR_IRQ_FLAG);
    chk(8'(d), 8'h02);
    wr(ADDR_IRQ_EN, 4'h3);
    repeat (3) @(posedge clk);
    chk({irq_t1, irq_t0}, 8'h02);
    $display("t_chain done");
  endtask : t_chain

  // A second reset in mid-run must clear state left by the chained test.
  task t_rerun;
    @(posedge clk);
    rst_b <= 1'b0;
    repeat (4) @(posedge clk);
    rst_b <= 1'b1;
    rdc(ADDR_T0_CNT_LO);
    chk(c, RST_COUNT);
    rdc(ADDR_T1_CNT_LO);
    chk(c, RST_COUNT);
    rd(ADDR_T1_RLD_LO);
    chk(8'(d), 8'(RST_NIBBLE));
    rd(ADDR_IRQ_FLAG);
    chk(8'(d), 8'h00);
    chk(8'({irq_t1, irq_t0}), 8'h00);
    chk(8'(tone_out_pin), 8'h01);
    $display("t_rerun done");
  endtask : t_rerun

  // --------------------------------------------------------------------
  // Main sequence and hang guard
  // --------------------------------------------------------------------
  initial begin
    clk = 1'b0;
    rst_b = 1'b0;
    req = '0;
    n_fail = 0;
    samples_checked = 0;
    repeat (4) @(posedge clk);
    rst_b <= 1'b1;
    t_reset();
    t_preload();
    t_timer();
    t_indep();
    t_event();
    t_tone();
    t_chain();
    t_rerun();
    give_verdict();
  end

  initial begin
    #2000000;
    n_fail++;
    give_verdict();
  end
endmodule : tb_dual_reload_down_timer
